//--- lcd_bias_pkg.sv
package lcd_bias_pkg;

    // mux rate encodings
    localparam logic [3:0] MUX_STATIC = 4'h0;
    localparam logic [3:0] MUX_MAX    = 4'h7;
    localparam logic [3:0] MUX_5      = 4'h4;

    // pump reference select encodings
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_EXTERNAL = 2'h1;

    // field widths and reset values
    localparam int          LEVEL_W         = 4;
    localparam int          REF_W           = 2;
    localparam int          AUTO_DIS_W      = 4;
    localparam logic [3:0]  LEVEL_RESET     = 4'h0;

    // peak voltage source
    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_SUPPLY,
        SRC_PUMP,
        SRC_EXTERNAL
    } vsrc_t;

    // pump supervision state
    typedef enum logic [1:0] {
        PUMP_IDLE,
        PUMP_RUN,
        PUMP_PAUSED,
        PUMP_FAULT
    } pump_state_t;

endpackage

//--- seg_pin_mux.sv
`timescale 1ns/1ps
// one shared pin: common line wins over segment select, else select picks lcd or gpio
module seg_pin_mux
(
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic is_shared,
    input  wire logic com_needed,
    input  wire logic seg_sel,
    output logic      pin_is_com_q,
    output logic      pin_is_lcd_q
);
    logic com_d;
    logic lcd_d;

    always_comb
    begin
        com_d = com_needed;
        // dedicated pins are always lcd regardless of the select bit
        lcd_d = com_needed | !is_shared | seg_sel;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pin_is_com_q <= 1'b0;
            pin_is_lcd_q <= 1'b0;
        end
        else
        begin
            pin_is_com_q <= com_d;
            pin_is_lcd_q <= lcd_d;
        end
    end
endmodule

//--- bias_select.sv
`timescale 1ns/1ps
// bias divider and pin routing for the intermediate levels
module bias_select
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       gen_allowed,
    input  wire logic [3:0] mux_rate,
    input  wire logic       half_bias_select,
    input  wire logic       bias_to_pins,
    input  wire logic       external_bias_select,
    input  wire logic       low_rail_external,
    output logic            divider_on_q,
    output logic            half_bias_q,
    output logic            top_rail_used_q,
    output logic            two_third_used_q,
    output logic            mid_bias_used_q,
    output logic            mid_is_half_q,
    output logic            low_rail_input_q
);
    logic is_static;
    logic half_eff;
    logic pins_used;
    logic div_d;
    logic half_d;
    logic top_d;
    logic two_d;
    logic mid_d;
    logic midh_d;
    logic low_d;

    always_comb
    begin
        is_static = (mux_rate == lcd_bias_pkg::MUX_STATIC);
        // 5-mux and above only run third bias
        half_eff  = half_bias_select && (mux_rate < lcd_bias_pkg::MUX_5);
        pins_used = bias_to_pins | external_bias_select;
        div_d     = gen_allowed && !is_static && !external_bias_select;
        half_d    = half_eff;
        top_d     = pins_used;
        two_d     = pins_used && !is_static && !half_eff;
        mid_d     = pins_used && !is_static;
        midh_d    = half_eff;
        low_d     = low_rail_external;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            divider_on_q     <= 1'b0;
            half_bias_q      <= 1'b0;
            top_rail_used_q  <= 1'b0;
            two_third_used_q <= 1'b0;
            mid_bias_used_q  <= 1'b0;
            mid_is_half_q    <= 1'b0;
            low_rail_input_q <= 1'b0;
        end
        else
        begin
            divider_on_q     <= div_d;
            half_bias_q      <= half_d;
            top_rail_used_q  <= top_d;
            two_third_used_q <= two_d;
            mid_bias_used_q  <= mid_d;
            mid_is_half_q    <= midh_d;
            low_rail_input_q <= low_d;
        end
    end
endmodule

//--- lcd_bias_supply_control.sv
`timescale 1ns/1ps
module lcd_bias_supply_control
#(
    parameter int           NUM_PINS    = 8,
    parameter logic [7:0]   SHARED_MASK = 8'hFE,
    parameter int           NUM_COMS    = 8
)
(
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  source_clock_off,
    input  wire logic                  module_on,
    input  wire logic                  external_voltage_select,
    input  wire logic [3:0]            pump_voltage_level,
    input  wire logic [1:0]            reference_select,
    input  wire logic                  pump_enable,
    input  wire logic                  pump_run_enable,
    input  wire logic [3:0]            pump_auto_disable_sel,
    input  wire logic [3:0]            auto_disable_active,
    input  wire logic [1:0]            pump_reference_select,
    input  wire logic                  bias_to_pins,
    input  wire logic                  external_bias_select,
    input  wire logic                  low_rail_external,
    input  wire logic                  half_bias_select,
    input  wire logic [3:0]            mux_rate,
    input  wire logic [NUM_PINS-1:0]   segment_pin_select,
    input  wire logic [NUM_PINS-1:0]   pin_com_index_valid,
    input  wire logic                  capacitor_present,
    input  wire logic                  missing_capacitor_clear,
    input  wire logic                  missing_capacitor_irq_enable,
    output logic [1:0]                 peak_source_q,
    output logic                       pump_on_q,
    output logic [3:0]                 pump_level_q,
    output logic                       pump_ext_ref_q,
    output logic                       pump_capacitor_pin_input_q,
    output logic                       top_rail_pin_drive_q,
    output logic                       top_rail_pin_input_q,
    output logic                       divider_on_q,
    output logic                       half_bias_q,
    output logic                       two_third_pin_used_q,
    output logic                       mid_bias_pin_used_q,
    output logic                       mid_is_half_q,
    output logic                       low_rail_pin_input_q,
    output logic [NUM_COMS-1:0]        common_line_active_q,
    output logic [NUM_PINS-1:0]        pin_is_com_q,
    output logic [NUM_PINS-1:0]        pin_is_lcd_q,
    output logic                       missing_capacitor_flag,
    output logic                       missing_capacitor_irq_q
);

    ////////////////////////////////////////////////////////////////////////////
    // voltage source selection

    logic                      gen_allowed;
    logic                      top_used;
    lcd_bias_pkg::vsrc_t       src_d;
    lcd_bias_pkg::vsrc_t       src_q;
    logic [3:0]                level_d;
    logic [3:0]                level_q;
    logic                      extref_d;
    logic                      extref_q;
    logic                      capin_d;
    logic                      capin_q;
    logic                      topdrv_d;
    logic                      topdrv_q;
    logic                      topin_d;
    logic                      topin_q;

    always_comb
    begin
        gen_allowed = !source_clock_off && module_on;
        if (!gen_allowed)
            src_d = lcd_bias_pkg::SRC_OFF;
        else if (external_voltage_select)
            src_d = lcd_bias_pkg::SRC_EXTERNAL;
        else if (pump_enable && pump_voltage_level != lcd_bias_pkg::LEVEL_RESET)
            src_d = lcd_bias_pkg::SRC_PUMP;
        else if (pump_voltage_level == lcd_bias_pkg::LEVEL_RESET && reference_select == 2'h0)
            src_d = lcd_bias_pkg::SRC_SUPPLY;
        else
            src_d = lcd_bias_pkg::SRC_OFF;
        level_d  = pump_voltage_level;
        extref_d = (pump_reference_select == lcd_bias_pkg::REF_EXTERNAL)
                   && !bias_to_pins && !external_bias_select;
        capin_d  = external_voltage_select;
        // ladder power can be switched off with the module: top pin driven only while generating
        topdrv_d = top_used && !external_voltage_select && gen_allowed;
        topin_d  = top_used && external_voltage_select;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            src_q    <= lcd_bias_pkg::SRC_OFF;
            level_q  <= lcd_bias_pkg::LEVEL_RESET;
            extref_q <= 1'b0;
            capin_q  <= 1'b0;
            topdrv_q <= 1'b0;
            topin_q  <= 1'b0;
        end
        else
        begin
            src_q    <= src_d;
            level_q  <= level_d;
            extref_q <= extref_d;
            capin_q  <= capin_d;
            topdrv_q <= topdrv_d;
            topin_q  <= topin_d;
        end
    end

    assign peak_source_q              = src_q;
    assign pump_level_q               = level_q;
    assign pump_ext_ref_q             = extref_q;
    assign pump_capacitor_pin_input_q = capin_q;
    assign top_rail_pin_drive_q       = topdrv_q;
    assign top_rail_pin_input_q       = topin_q;

    ////////////////////////////////////////////////////////////////////////////
    // pump supervision

    lcd_bias_pkg::pump_state_t pst_d;
    lcd_bias_pkg::pump_state_t pst_q;
    logic                      pump_want;
    logic                      auto_off;
    logic                      flag_d;
    logic                      flag_q;
    logic                      on_d;
    logic                      on_q;
    logic                      irq_d;
    logic                      irq_q;

    always_comb
    begin
        pump_want = gen_allowed && !external_voltage_select && pump_enable
                    && pump_voltage_level != lcd_bias_pkg::LEVEL_RESET;
        auto_off  = |(pump_auto_disable_sel & auto_disable_active);
        pst_d     = pst_q;
        case (pst_q)
            lcd_bias_pkg::PUMP_IDLE:
                // a start while paused must not pulse the pump for one cycle
                if (pump_want && (!pump_run_enable || auto_off))
                    pst_d = lcd_bias_pkg::PUMP_PAUSED;
                else if (pump_want)
                    pst_d = lcd_bias_pkg::PUMP_RUN;
            lcd_bias_pkg::PUMP_RUN, lcd_bias_pkg::PUMP_PAUSED:
                if (!pump_want)
                    pst_d = lcd_bias_pkg::PUMP_IDLE;
                else if (!capacitor_present)
                    pst_d = lcd_bias_pkg::PUMP_FAULT;
                else if (!pump_run_enable || auto_off)
                    pst_d = lcd_bias_pkg::PUMP_PAUSED;
                else
                    pst_d = lcd_bias_pkg::PUMP_RUN;
            lcd_bias_pkg::PUMP_FAULT:
                // stays off until software drops the pump enable and sets it again
                if (!pump_enable)
                    pst_d = lcd_bias_pkg::PUMP_IDLE;
            default:
                pst_d = lcd_bias_pkg::PUMP_IDLE;
        endcase
        // set wins over a clear in the same cycle
        flag_d = (pst_d == lcd_bias_pkg::PUMP_FAULT && pst_q != lcd_bias_pkg::PUMP_FAULT)
                 || (flag_q && !missing_capacitor_clear);
        on_d   = (pst_d == lcd_bias_pkg::PUMP_RUN);
        irq_d  = flag_d && missing_capacitor_irq_enable;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pst_q  <= lcd_bias_pkg::PUMP_IDLE;
            flag_q <= 1'b0;
            on_q   <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            pst_q  <= pst_d;
            flag_q <= flag_d;
            on_q   <= on_d;
            irq_q  <= irq_d;
        end
    end

    assign pump_on_q               = on_q;
    assign missing_capacitor_flag  = flag_q;
    assign missing_capacitor_irq_q = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // bias generation

    bias_select u_bias
    (
        .mclk                 (mclk),
        .srst                 (srst),
        .gen_allowed          (gen_allowed),
        .mux_rate             (mux_rate),
        .half_bias_select     (half_bias_select),
        .bias_to_pins         (bias_to_pins),
        .external_bias_select (external_bias_select),
        .low_rail_external    (low_rail_external),
        .divider_on_q         (divider_on_q),
        .half_bias_q          (half_bias_q),
        .top_rail_used_q      (top_used),
        .two_third_used_q     (two_third_pin_used_q),
        .mid_bias_used_q      (mid_bias_pin_used_q),
        .mid_is_half_q        (mid_is_half_q),
        .low_rail_input_q     (low_rail_pin_input_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // common lines and pin functions

    logic [NUM_COMS-1:0] com_d;
    logic [NUM_COMS-1:0] com_q;
    logic [3:0]          rate_clip;

    always_comb
    begin
        // codes above 0111 are treated as 8 commons
        rate_clip = (mux_rate > lcd_bias_pkg::MUX_MAX) ? lcd_bias_pkg::MUX_MAX : mux_rate;
        for (int i = 0; i < NUM_COMS; i++)
            com_d[i] = (i <= int'(rate_clip));
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            com_q <= '0;
        else
            com_q <= com_d;
    end

    assign common_line_active_q = com_q;

    // pin k is assumed to double as common line k when pin_com_index_valid[k] is set
    for (genvar k = 0; k < NUM_PINS; k++)
    begin : g_pin
        seg_pin_mux u_pin
        (
            .mclk         (mclk),
            .srst         (srst),
            .is_shared    (SHARED_MASK[k]),
            .com_needed   (pin_com_index_valid[k] && k < NUM_COMS && com_d[k % NUM_COMS]),
            .seg_sel      (segment_pin_select[k]),
            .pin_is_com_q (pin_is_com_q[k]),
            .pin_is_lcd_q (pin_is_lcd_q[k])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_fault_entry;
        pst_q == lcd_bias_pkg::PUMP_RUN && pump_want && !capacitor_present;
    endsequence

    sequence s_resume_ready;
        pst_q == lcd_bias_pkg::PUMP_PAUSED && pump_want && capacitor_present && pump_run_enable && !auto_off;
    endsequence

    AST_OFF_WHEN_DISABLED: assert property (@(posedge mclk) disable iff (srst)
        (source_clock_off || !module_on) |=> (src_q == lcd_bias_pkg::SRC_OFF && !on_q))
        else $error("generation active while disabled");
    AST_SUPPLY: assert property (@(posedge mclk) disable iff (srst)
        (gen_allowed && !external_voltage_select && pump_voltage_level == 4'h0 && reference_select == 2'h0)
        |=> src_q == lcd_bias_pkg::SRC_SUPPLY)
        else $error("supply rail not selected");
    AST_PUMP_SRC: assert property (@(posedge mclk) disable iff (srst)
        (gen_allowed && !external_voltage_select && pump_enable && pump_voltage_level != 4'h0)
        |=> src_q == lcd_bias_pkg::SRC_PUMP)
        else $error("pump not selected");
    AST_NOCAP: assert property (@(posedge mclk) disable iff (srst)
        s_fault_entry |=> (flag_q && !on_q) ##1 !on_q)
        else $error("missing capacitor not handled");
    AST_PAUSE: assert property (@(posedge mclk) disable iff (srst)
        !pump_run_enable |=> !on_q)
        else $error("pump runs while paused");
    AST_RESUME: assert property (@(posedge mclk) disable iff (srst)
        s_resume_ready |=> on_q)
        else $error("pump did not resume");
    AST_AUTO_OFF: assert property (@(posedge mclk) disable iff (srst)
        auto_off |=> !on_q)
        else $error("pump not suspended");
    AST_EXT_REF: assert property (@(posedge mclk) disable iff (srst)
        (pump_reference_select == lcd_bias_pkg::REF_EXTERNAL && !bias_to_pins && !external_bias_select)
        |=> pump_ext_ref_q)
        else $error("external reference not used");
    AST_EXT_VOLT: assert property (@(posedge mclk) disable iff (srst)
        external_voltage_select |=> (!on_q && capin_q && !topdrv_q))
        else $error("external voltage not honoured");
    AST_TOP_DRIVE: assert property (@(posedge mclk) disable iff (srst)
        (top_used && !external_voltage_select && gen_allowed) |=> topdrv_q)
        else $error("ladder supply not switched on");
    // divider outputs come from the bias flops, one cycle after the inputs
    AST_DIV_OFF: assert property (@(posedge mclk) disable iff (srst)
        (external_bias_select || mux_rate == lcd_bias_pkg::MUX_STATIC) |=> !divider_on_q)
        else $error("divider on with external bias or static");
    AST_HALF_LIMIT: assert property (@(posedge mclk) disable iff (srst)
        (mux_rate >= lcd_bias_pkg::MUX_5) |=> !half_bias_q)
        else $error("half bias at five commons or more");
    AST_LEVEL: assert property (@(posedge mclk) disable iff (srst)
        1'b1 |=> level_q == $past(pump_voltage_level))
        else $error("pump level not applied");
    AST_FLAG_STICKS: assert property (@(posedge mclk) disable iff (srst)
        (flag_q && !missing_capacitor_clear && !$rose(pst_q == lcd_bias_pkg::PUMP_FAULT)) |=> flag_q)
        else $error("flag lost without clear");
    AST_FAULT_HOLD: assert property (@(posedge mclk) disable iff (srst)
        (pst_q == lcd_bias_pkg::PUMP_FAULT && pump_enable) |=> (pst_q == lcd_bias_pkg::PUMP_FAULT && !on_q))
        else $error("pump left fault without re-enable");
    AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (srst)
        irq_q |-> (flag_q && $past(missing_capacitor_irq_enable)))
        else $error("irq without flag and enable");
    AST_COM_COUNT: assert property (@(posedge mclk) disable iff (srst)
        (mux_rate == 4'h0) |=> com_q[0] && !com_q[1])
        else $error("static mode common count wrong");

endmodule

//--- lcd_glass_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far side: glass and pump capacitor, the capacitor only sensed as fitted or not
module lcd_glass_model
(
    input  wire logic mclk,
    input  wire logic cap_fitted,
    output logic      capacitor_present
);
    // detector reacts a cycle late, as a real sense comparator would
    always_ff @(posedge mclk)
    begin
        capacitor_present <= cap_fitted;
    end
endmodule

//--- lcd_bias_supply_control_tb_top.sv
`timescale 1ns/1ps
module lcd_bias_supply_control_tb_top;
    logic       mclk, srst, source_clock_off, module_on, external_voltage_select, pump_enable, pump_run_enable;
    logic       bias_to_pins, external_bias_select, low_rail_external, half_bias_select, cap_fitted;
    logic       capacitor_present, missing_capacitor_clear, missing_capacitor_irq_enable;
    logic [3:0] pump_voltage_level, pump_auto_disable_sel, auto_disable_active, mux_rate, pump_level_q;
    logic [1:0] reference_select, pump_reference_select, peak_source_q;
    logic [7:0] segment_pin_select, pin_com_index_valid, pin_is_com_q, pin_is_lcd_q, common_line_active_q;
    logic       pump_on_q, pump_ext_ref_q, pump_capacitor_pin_input_q, top_rail_pin_drive_q, top_rail_pin_input_q;
    logic       divider_on_q, half_bias_q, two_third_pin_used_q, mid_bias_pin_used_q, mid_is_half_q;
    logic       low_rail_pin_input_q, missing_capacitor_flag, missing_capacitor_irq_q;
    int         n_fail, tests_run, cycles;

    lcd_bias_supply_control lcd_bias_supply_control_inst
    (
        .mclk, .srst, .source_clock_off, .module_on, .external_voltage_select, .pump_voltage_level,
        .reference_select, .pump_enable, .pump_run_enable, .pump_auto_disable_sel, .auto_disable_active,
        .pump_reference_select, .bias_to_pins, .external_bias_select, .low_rail_external, .half_bias_select,
        .mux_rate, .segment_pin_select, .pin_com_index_valid, .capacitor_present, .missing_capacitor_clear,
        .missing_capacitor_irq_enable, .peak_source_q, .pump_on_q, .pump_level_q, .pump_ext_ref_q,
        .pump_capacitor_pin_input_q, .top_rail_pin_drive_q, .top_rail_pin_input_q, .divider_on_q, .half_bias_q,
        .two_third_pin_used_q, .mid_bias_pin_used_q, .mid_is_half_q, .low_rail_pin_input_q,
        .common_line_active_q, .pin_is_com_q, .pin_is_lcd_q, .missing_capacitor_flag, .missing_capacitor_irq_q
    );

    lcd_glass_model lcd_glass_model_inst (.mclk, .cap_fitted, .capacitor_present);

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    task complete_run;
        $display("tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // outputs are levels with at most two cycles of lag, four is ample
    task settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_supply;
        @(posedge mclk);
        module_on <= 1'b1;
        settle();
        chk("peak_supply", 2'h1, peak_source_q);
        @(posedge mclk);
        reference_select <= 2'h1;
        settle();
        chk("peak_ref_nonzero", 2'h0, peak_source_q);
        @(posedge mclk);
        reference_select <= 2'h0;
        module_on <= 1'b0;
        settle();
        chk("peak_module_off", 2'h0, peak_source_q);
        $display("test supply done");
    endtask

    task t_pump;
        @(posedge mclk);
        module_on <= 1'b1;
        pump_enable <= 1'b1;
        pump_voltage_level <= 4'h3;
        settle();
        chk("peak_pump", 2'h2, peak_source_q);
        chk("pump_on", 1'b1, pump_on_q);
        chk("pump_level", 4'h3, pump_level_q);
        @(posedge mclk);
        pump_voltage_level <= 4'hF;
        pump_run_enable <= 1'b0;
        settle();
        chk("pump_level_max", 4'hF, pump_level_q);
        chk("pump_paused", 1'b0, pump_on_q);
        @(posedge mclk);
        pump_run_enable <= 1'b1;
        pump_auto_disable_sel <= 4'h2;
        auto_disable_active <= 4'h1;
        settle();
        chk("pump_resumed", 1'b1, pump_on_q);
        @(posedge mclk);
        auto_disable_active <= 4'h2;
        settle();
        chk("pump_auto_off", 1'b0, pump_on_q);
        @(posedge mclk);
        auto_disable_active <= 4'h0;
        pump_reference_select <= 2'h1;
        settle();
        chk("pump_auto_back", 1'b1, pump_on_q);
        chk("ext_ref", 1'b1, pump_ext_ref_q);
        @(posedge mclk);
        bias_to_pins <= 1'b1;
        settle();
        chk("ext_ref_routed", 1'b0, pump_ext_ref_q);
        @(posedge mclk);
        bias_to_pins <= 1'b0;
        pump_reference_select <= 2'h0;
        source_clock_off <= 1'b1;
        settle();
        chk("pump_clock_off", 1'b0, pump_on_q);
        chk("peak_clock_off", 2'h0, peak_source_q);
        @(posedge mclk);
        source_clock_off <= 1'b0;
        settle();
        $display("test pump done");
    endtask

    task t_nocap;
        @(posedge mclk);
        cap_fitted <= 1'b0;
        settle();
        chk("flag_set", 1'b1, missing_capacitor_flag);
        chk("pump_forced_off", 1'b0, pump_on_q);
        chk("irq_masked", 1'b0, missing_capacitor_irq_q);
        @(posedge mclk);
        missing_capacitor_irq_enable <= 1'b1;
        cap_fitted <= 1'b1;
        settle();
        chk("irq_enabled", 1'b1, missing_capacitor_irq_q);
        chk("flag_sticky", 1'b1, missing_capacitor_flag);
        chk("pump_stays_off", 1'b0, pump_on_q);
        @(posedge mclk);
        missing_capacitor_clear <= 1'b1;
        @(posedge mclk);
        missing_capacitor_clear <= 1'b0;
        settle();
        chk("flag_cleared", 1'b0, missing_capacitor_flag);
        chk("pump_off_after_clear", 1'b0, pump_on_q);
        @(posedge mclk);
        pump_enable <= 1'b0;
        settle();
        @(posedge mclk);
        pump_enable <= 1'b1;
        settle();
        chk("pump_reenabled", 1'b1, pump_on_q);
        $display("test no capacitor done");
    endtask

    task t_ext;
        @(posedge mclk);
        external_voltage_select <= 1'b1;
        external_bias_select <= 1'b1;
        settle();
        chk("peak_external", 2'h3, peak_source_q);
        chk("pump_ext_off", 1'b0, pump_on_q);
        chk("cap_pin_input", 1'b1, pump_capacitor_pin_input_q);
        chk("top_rail_input", 1'b1, top_rail_pin_input_q);
        chk("top_rail_no_drive", 1'b0, top_rail_pin_drive_q);
        @(posedge mclk);
        external_voltage_select <= 1'b0;
        settle();
        chk("top_rail_drive", 1'b1, top_rail_pin_drive_q);
        chk("top_rail_not_input", 1'b0, top_rail_pin_input_q);
        @(posedge mclk);
        external_bias_select <= 1'b0;
        pump_enable <= 1'b0;
        settle();
        $display("test external supply done");
    endtask

    task t_bias;
        logic hb;
        for (int m = 0; m < 9; m++)
        begin
            for (int h = 0; h < 2; h++)
            begin
                @(posedge mclk);
                mux_rate <= (m == 8) ? 4'hF : 4'(m);
                half_bias_select <= h[0];
                bias_to_pins <= 1'b1;
                settle();
                hb = h[0] && m >= 1 && m <= 3;
                chk("commons", (32'h1 << ((m == 8 ? 7 : m) + 1)) - 1, common_line_active_q);
                chk("divider", m != 0, divider_on_q);
                if (m != 0)
                begin
                    chk("half_bias", hb, half_bias_q);
                    chk("mid_pin", 1'b1, mid_bias_pin_used_q);
                    chk("two_third_pin", !hb, two_third_pin_used_q);
                    chk("mid_is_half", hb, mid_is_half_q);
                end
            end
        end
        @(posedge mclk);
        mux_rate <= 4'h3;
        bias_to_pins <= 1'b0;
        settle();
        chk("mid_pin_unrouted", 1'b0, mid_bias_pin_used_q);
        @(posedge mclk);
        external_bias_select <= 1'b1;
        low_rail_external <= 1'b1;
        settle();
        chk("divider_ext_bias", 1'b0, divider_on_q);
        chk("mid_pin_ext_bias", 1'b1, mid_bias_pin_used_q);
        chk("low_rail_input", 1'b1, low_rail_pin_input_q);
        @(posedge mclk);
        external_bias_select <= 1'b0;
        low_rail_external <= 1'b0;
        $display("test bias done");
    endtask

    task t_pins;
        logic [7:0] sel, com;
        for (int m = 0; m < 8; m++)
        begin
            sel = m[0] ? 8'h5A : 8'hA4;
            for (int k = 0; k < 8; k++)
                com[k] = k > 0 && k <= m && k < 4;
            @(posedge mclk);
            mux_rate <= 4'(m);
            segment_pin_select <= sel;
            pin_com_index_valid <= 8'h0E;
            settle();
            chk("pin_com", com[7:1], pin_is_com_q[7:1]);
            chk("pin_lcd_shared", sel[7:1] & ~com[7:1], pin_is_lcd_q[7:1] & ~com[7:1]);
            chk("pin_lcd_dedicated", 1'b1, pin_is_lcd_q[0]);
        end
        $display("test pins done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {srst, pump_run_enable, cap_fitted} = 3'h7;
        {source_clock_off, module_on, external_voltage_select, pump_enable, bias_to_pins} = 5'h0;
        {external_bias_select, low_rail_external, half_bias_select} = 3'h0;
        {missing_capacitor_clear, missing_capacitor_irq_enable} = 2'h0;
        {pump_voltage_level, pump_auto_disable_sel, auto_disable_active, mux_rate} = 16'h0;
        {reference_select, pump_reference_select, segment_pin_select, pin_com_index_valid} = 20'h0;
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        repeat (20) @(posedge mclk);
        #1;
        chk("reset_peak", 2'h0, peak_source_q);
        chk("reset_flag", 1'b0, missing_capacitor_flag);
        @(posedge mclk);
        srst <= 1'b0;
        t_supply();
        t_pump();
        t_nocap();
        t_ext();
        t_bias();
        t_pins();
        complete_run();
    end
endmodule
